// >>> rtl/sim_source_pkg.sv
// Constants and types shared by the simulation sample source
package sim_source_pkg;
   localparam int SAMPLE_W = 16;
   localparam int CHAN_W = 4;
   localparam int CYCLE_SAMPLES = 64;
   localparam int PLAY_CYCLES = 16;
   localparam int PLAY_CHANNELS = 16;
   localparam int PLAY_DEPTH = PLAY_CYCLES * CYCLE_SAMPLES * PLAY_CHANNELS;
   localparam int PLAY_AW = 14;
   localparam int PTR_W = 10;
   localparam logic [PTR_W-1:0] PTR_LAST = 10'h3FF;
   localparam logic [CHAN_W-1:0] CHAN_LAST = 4'hF;
   localparam int RELAYS = 8;
   localparam logic [RELAYS-1:0] BLOCK_MASK_RESET = 8'hFF;
   localparam int MAG_W = 9;
   localparam logic [MAG_W-1:0] CUR_MAG_MAX = 9'h190;
   localparam logic [MAG_W-1:0] CUR_MAG_DEFAULT = 9'h00A;
   localparam int VMAG_W = 5;
   localparam logic [VMAG_W-1:0] VOLT_MAG_MAX = 5'h14;
   localparam logic [VMAG_W-1:0] VOLT_MAG_DEFAULT = 5'h0A;
   localparam int ANG_W = 9;
   localparam logic [ANG_W-1:0] ANG_FULL = 9'h168;
   localparam logic [ANG_W-1:0] ANG_B_LAG = 9'h0F0;
   localparam logic [ANG_W-1:0] ANG_C_LAG = 9'h078;
   localparam logic [ANG_W-1:0] ANG_REF = 9'h000;
   localparam int FREQ_W = 13;
   localparam int TRIG_W = 5;
   localparam logic [TRIG_W-1:0] TRIG_DISABLED = 5'h00;
   localparam int WINDINGS = 3;
   localparam int PHASES = 3;

   typedef enum logic [1:0] {
      SIM_OFF = 2'b00,
      SIM_PREFAULT = 2'b01,
      SIM_FAULT = 2'b10,
      SIM_PLAYBACK = 2'b11
   } sim_mode_t;
endpackage : sim_source_pkg

// >>> rtl/sim_sample_source.sv
// Simulation mode control and sample source selection for a relay
`timescale 1ns/1ns
`default_nettype none
module sim_sample_source (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire logic [1:0] simSelect,
   input wire logic [7:0] outputBlockMask,
   input wire logic [4:0] faultStartSel,
   input wire logic [4:0] playbackStartSel,
   input wire logic [15:0] logicIn,
   input wire logic [7:0] relayCmd,
   input wire logic realValid,
   input wire logic [3:0] realChan,
   input wire logic [15:0] realData,
   input wire logic [15:0] synthData,
   input wire logic [2:0][8:0] pfCurMag,
   input wire logic [4:0] pfVoltMag,
   input wire logic [12:0] nominalFreq,
   input wire logic [2:0][8:0] windingShift,
   input wire logic [2:0][2:0][8:0] faultCurMag,
   input wire logic [2:0][2:0][8:0] faultCurAng,
   input wire logic [2:0][8:0] faultGndMag,
   input wire logic [2:0][8:0] faultGndAng,
   input wire logic [4:0] faultVoltMag,
   input wire logic [8:0] faultVoltAng,
   input wire logic [12:0] faultFreq,
   input wire logic playWrEn,
   input wire logic [13:0] playWrAddr,
   input wire logic [15:0] playWrData,
   output logic [1:0] simMode,
   output logic sampleValid,
   output logic [3:0] sampleChan,
   output logic [15:0] sampleData,
   output logic [2:0][2:0][8:0] genCurMag,
   output logic [2:0][2:0][8:0] genCurAng,
   output logic [2:0][8:0] genGndMag,
   output logic [2:0][8:0] genGndAng,
   output logic [4:0] genVoltMag,
   output logic [8:0] genVoltAng,
   output logic [12:0] genFreq,
   output logic inServiceLed,
   output logic testModeLed,
   output logic selfTestRelay,
   output logic [7:0] relayOut
);

   // Angle sum wrapped into 0..359
   function automatic logic [8:0] addAngle(input logic [8:0] a,
                                           input logic [8:0] b);
      logic [9:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, sim_source_pkg::ANG_FULL}) begin
         s = s - {1'b0, sim_source_pkg::ANG_FULL};
      end
      return s[8:0];
   endfunction : addAngle

   // Trigger select: 0 means disabled, 1..16 picks a logic input
   function automatic logic trigPick(input logic [4:0] sel,
                                     input logic [15:0] rise);
      logic hit;
      hit = 1'b0;
      if (sel != sim_source_pkg::TRIG_DISABLED && sel <= 5'h10) begin
         hit = rise[4'(sel - 5'h01)];
      end
      return hit;
   endfunction : trigPick

   // Reset release and logic input synchronisers
   logic rstMeta_q;
   logic rstSync_q;
   logic [15:0] inMeta_q;
   logic [15:0] inSync_q;
   logic [15:0] inPrev_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   wire rstn = rstSync_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         inMeta_q <= 16'h0000;
         inSync_q <= 16'h0000;
         inPrev_q <= 16'h0000;
      end else if (clkEn) begin
         inMeta_q <= logicIn;
         inSync_q <= inMeta_q;
         inPrev_q <= inSync_q;
      end
   end

   wire [15:0] inRise = inSync_q & ~inPrev_q;

   // Mode state: follows the selector when it changes, triggers from prefault
   sim_source_pkg::sim_mode_t mode_q, mode_d;
   logic [1:0] selPrev_q, selPrev_d;
   logic faultTrig;
   logic playTrig;

   always_comb begin
      faultTrig = trigPick(faultStartSel, inRise);
      playTrig = trigPick(playbackStartSel, inRise);
      selPrev_d = simSelect;
      mode_d = mode_q;
      if (simSelect != selPrev_q) begin
         mode_d = sim_source_pkg::sim_mode_t'(simSelect);
      end else begin
         case (mode_q)
            sim_source_pkg::SIM_PREFAULT: begin
               // Fault start wins when both triggers rise together
               if (faultTrig) begin
                  mode_d = sim_source_pkg::SIM_FAULT;
               end else if (playTrig) begin
                  mode_d = sim_source_pkg::SIM_PLAYBACK;
               end
            end
            sim_source_pkg::SIM_OFF,
            sim_source_pkg::SIM_FAULT,
            sim_source_pkg::SIM_PLAYBACK: begin
               mode_d = mode_q;
            end
            default: begin
               mode_d = sim_source_pkg::SIM_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= sim_source_pkg::SIM_OFF;
         selPrev_q <= 2'b00;
      end else if (clkEn) begin
         mode_q <= mode_d;
         selPrev_q <= selPrev_d;
      end
   end

   wire simActive = (mode_q != sim_source_pkg::SIM_OFF);

   // Phasor descriptors handed to the sample synthesiser
   logic [2:0][2:0][8:0] curMag_q, curMag_d;
   logic [2:0][2:0][8:0] curAng_q, curAng_d;
   logic [2:0][8:0] gndMag_q, gndMag_d;
   logic [2:0][8:0] gndAng_q, gndAng_d;
   logic [4:0] voltMag_q, voltMag_d;
   logic [8:0] voltAng_q, voltAng_d;
   logic [12:0] freq_q, freq_d;

   always_comb begin
      curMag_d = '0;
      curAng_d = '0;
      gndMag_d = '0;
      gndAng_d = '0;
      voltMag_d = '0;
      voltAng_d = sim_source_pkg::ANG_REF;
      freq_d = nominalFreq;
      if (mode_q == sim_source_pkg::SIM_PREFAULT) begin
         for (int w = 0; w < sim_source_pkg::WINDINGS; w++) begin
            // Out-of-range prefault magnitudes are clamped to the top of the range
            for (int p = 0; p < sim_source_pkg::PHASES; p++) begin
               curMag_d[w][p] = (pfCurMag[w] > sim_source_pkg::CUR_MAG_MAX)
                  ? sim_source_pkg::CUR_MAG_MAX : pfCurMag[w];
            end
            curAng_d[w][0] = windingShift[w];
            curAng_d[w][1] = addAngle(windingShift[w],
                                      sim_source_pkg::ANG_B_LAG);
            curAng_d[w][2] = addAngle(windingShift[w],
                                      sim_source_pkg::ANG_C_LAG);
         end
         voltMag_d = (pfVoltMag > sim_source_pkg::VOLT_MAG_MAX)
            ? sim_source_pkg::VOLT_MAG_MAX : pfVoltMag;
         freq_d = nominalFreq;
      end else if (mode_q == sim_source_pkg::SIM_FAULT) begin
         curMag_d = faultCurMag;
         curAng_d = faultCurAng;
         curAng_d[0][0] = sim_source_pkg::ANG_REF;
         gndMag_d = faultGndMag;
         gndAng_d = faultGndAng;
         voltMag_d = faultVoltMag;
         voltAng_d = faultVoltAng;
         freq_d = faultFreq;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         curMag_q <= '0;
         curAng_q <= '0;
         gndMag_q <= '0;
         gndAng_q <= '0;
         voltMag_q <= 5'h00;
         voltAng_q <= 9'h000;
         freq_q <= 13'h0000;
      end else if (clkEn) begin
         curMag_q <= curMag_d;
         curAng_q <= curAng_d;
         gndMag_q <= gndMag_d;
         gndAng_q <= gndAng_d;
         voltMag_q <= voltMag_d;
         voltAng_q <= voltAng_d;
         freq_q <= freq_d;
      end
   end

   // Playback record: 16 cycles x 64 samples x 16 channels
   logic [15:0] playMem [0:sim_source_pkg::PLAY_DEPTH-1];
   logic [9:0] playPtr_q, playPtr_d;

   always_ff @(posedge clk) begin
      if (clkEn && playWrEn) begin
         playMem[playWrAddr] <= playWrData;
      end
   end

   always_comb begin
      playPtr_d = playPtr_q;
      if (mode_q != sim_source_pkg::SIM_PLAYBACK) begin
         playPtr_d = 10'h000;
      end else if (realValid && realChan == sim_source_pkg::CHAN_LAST) begin
         // Record loops once all sixteen cycles have been replayed
         playPtr_d = playPtr_q + 10'h001;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         playPtr_q <= 10'h000;
      end else if (clkEn) begin
         playPtr_q <= playPtr_d;
      end
   end

   // Sample path: one stream, timing set by the real sampler
   logic sampleValid_q, sampleValid_d;
   logic [3:0] sampleChan_q, sampleChan_d;
   logic [15:0] sampleData_q, sampleData_d;

   always_comb begin
      sampleValid_d = realValid;
      sampleChan_d = realChan;
      case (mode_q)
         sim_source_pkg::SIM_OFF: sampleData_d = realData;
         sim_source_pkg::SIM_PREFAULT,
         sim_source_pkg::SIM_FAULT: sampleData_d = synthData;
         sim_source_pkg::SIM_PLAYBACK: begin
            sampleData_d = playMem[{playPtr_q, realChan}];
         end
         default: sampleData_d = realData;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sampleValid_q <= 1'b0;
         sampleChan_q <= 4'h0;
         sampleData_q <= 16'h0000;
      end else if (clkEn) begin
         sampleValid_q <= sampleValid_d;
         sampleChan_q <= sampleChan_d;
         sampleData_q <= sampleData_d;
      end
   end

   // Indicators, self-test relay and output blocking
   logic inService_q, inService_d;
   logic selfTest_q, selfTest_d;
   logic [7:0] relay_q, relay_d;

   always_comb begin
      inService_d = !simActive;
      selfTest_d = !simActive;
      relay_d = simActive ? (relayCmd & ~outputBlockMask) : relayCmd;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         inService_q <= 1'b1;
         selfTest_q <= 1'b1;
         relay_q <= 8'h00;
      end else if (clkEn) begin
         inService_q <= inService_d;
         selfTest_q <= selfTest_d;
         relay_q <= relay_d;
      end
   end

   assign simMode = mode_q;
   assign sampleValid = sampleValid_q;
   assign sampleChan = sampleChan_q;
   assign sampleData = sampleData_q;
   assign genCurMag = curMag_q;
   assign genCurAng = curAng_q;
   assign genGndMag = gndMag_q;
   assign genGndAng = gndAng_q;
   assign genVoltMag = voltMag_q;
   assign genVoltAng = voltAng_q;
   assign genFreq = freq_q;
   assign inServiceLed = inService_q;
   assign testModeLed = !inService_q;
   assign selfTestRelay = selfTest_q;
   assign relayOut = relay_q;

   // Checks start one enabled edge after release: the edge that still
   // sees reset must not be judged against inputs taken before it
   logic checkArmed_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         checkArmed_q <= 1'b0;
      end else if (clkEn) begin
         checkArmed_q <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!checkArmed_q);

   sequence seqPrefaultHeld;
      clkEn && mode_q == sim_source_pkg::SIM_PREFAULT
         && simSelect == selPrev_q;
   endsequence

   a_fault_trigger_moves: assert property (
      seqPrefaultHeld ##0 faultTrig |=> mode_q == sim_source_pkg::SIM_FAULT)
      else $error("fault trigger did not start fault mode");

   a_play_trigger_moves: assert property (
      seqPrefaultHeld ##0 (playTrig && !faultTrig)
         |=> mode_q == sim_source_pkg::SIM_PLAYBACK)
      else $error("playback trigger did not start playback");

   a_trigger_needs_prefault: assert property (
      clkEn && mode_q == sim_source_pkg::SIM_OFF && simSelect == selPrev_q
         |=> mode_q == sim_source_pkg::SIM_OFF)
      else $error("mode left off without selector change");

   a_held_input_once: assert property (
      seqPrefaultHeld ##0 (inSync_q & ~inPrev_q) == 16'h0000
         |=> mode_q == sim_source_pkg::SIM_PREFAULT)
      else $error("prefault left without a new input edge");

   a_selector_followed: assert property (
      clkEn && simSelect != selPrev_q |=> simMode == $past(simSelect))
      else $error("mode did not follow selector");

   a_indicators_follow: assert property (
      clkEn && simActive |=> !inServiceLed && testModeLed && !selfTestRelay)
      else $error("indicators wrong in simulation");

   a_mask_blocks: assert property (
      clkEn && simActive |=> (relayOut & $past(outputBlockMask)) == 8'h00)
      else $error("blocked relay operated");

   a_off_restores: assert property (
      clkEn && !simActive |=> selfTestRelay && relayOut == $past(relayCmd))
      else $error("off mode did not restore relays");

   a_real_in_off: assert property (
      clkEn && mode_q == sim_source_pkg::SIM_OFF
         |=> sampleData == $past(realData))
      else $error("real sample not passed in off mode");

   a_synth_in_sim: assert property (
      clkEn && mode_q == sim_source_pkg::SIM_FAULT
         |=> sampleData == $past(synthData) && genCurAng[0][0] == 9'h000)
      else $error("fault mode sample or reference wrong");

   a_prefault_balanced: assert property (
      clkEn && mode_q == sim_source_pkg::SIM_PREFAULT
         ##1 mode_q == sim_source_pkg::SIM_PREFAULT
         |-> genCurMag[1][0] == genCurMag[1][1]
            && genCurMag[1][1] == genCurMag[1][2])
      else $error("prefault currents not balanced");

endmodule : sim_sample_source
`default_nettype wire

// >>> tb/logic_input_bank.sv
// Partner model: a bank of sixteen contact inputs pressed by the bench
`timescale 1ns/1ns
`default_nettype none
module logic_input_bank (
   input wire logic clk,
   input wire logic press,
   input wire logic letGo,
   input wire logic [3:0] pinIdx,
   input wire logic [7:0] holdCycles,
   output logic [15:0] logicIn
);
   logic [7:0] countQ;
   logic [3:0] idxQ;
   initial begin
      logicIn = 16'h0000;
      countQ = 8'h00;
      idxQ = 4'h0;
   end
   // A hold of zero keeps the contact closed until the bench lets go
   always @(posedge clk) begin
      if (press) begin
         logicIn[pinIdx] <= 1'b1;
         idxQ <= pinIdx;
         countQ <= holdCycles;
      end else if (letGo || countQ == 8'h01) begin
         logicIn[idxQ] <= 1'b0;
         countQ <= 8'h00;
      end else if (countQ != 8'h00) begin
         countQ <= countQ - 8'h01;
      end
   end
endmodule : logic_input_bank
`default_nettype wire

// >>> tb/sim_sample_source_tb.sv
// Self-checking bench for the simulation sample source
`timescale 1ns/1ns
`default_nettype none
module sim_sample_source_tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic clkEn = 1'b1;
   logic [1:0] simSelect = 2'h0;
   logic [7:0] outputBlockMask = 8'hFF;
   logic [4:0] faultStartSel = 5'h00;
   logic [4:0] playbackStartSel = 5'h00;
   logic [7:0] relayCmd = 8'h00;
   logic realValid = 1'b0;
   logic [3:0] realChan = 4'h0;
   logic [15:0] realData = 16'h0000;
   logic [15:0] synthData = 16'h0000;
   logic playWrEn = 1'b0;
   logic [13:0] playWrAddr = 14'h0000;
   logic [15:0] playWrData = 16'h0000;
   logic press = 1'b0;
   logic letGo = 1'b0;
   logic [3:0] pinIdx = 4'h0;
   logic [7:0] holdCycles = 8'h00;
   logic [15:0] logicIn;
   logic [2:0][8:0] pfCurMag, windingShift, faultGndMag, faultGndAng;
   logic [2:0][2:0][8:0] faultCurMag, faultCurAng, genCurMag, genCurAng;
   logic [2:0][8:0] genGndMag, genGndAng;
   logic [4:0] pfVoltMag, faultVoltMag, genVoltMag;
   logic [8:0] faultVoltAng, genVoltAng;
   logic [12:0] nominalFreq, faultFreq, genFreq;
   logic [1:0] simMode;
   logic [3:0] sampleChan;
   logic [15:0] sampleData;
   logic sampleValid, inServiceLed, testModeLed, selfTestRelay;
   logic [7:0] relayOut;
   logic [31:0] seed = 32'h8049;
   logic [15:0] playRec [0:31];
   logic [19:0] expQ [$];
   int nErrors = 0;
   int nCompared = 0;
   int cycles = 0;

   logic_input_bank inputs (.clk(clk), .press(press), .letGo(letGo),
      .pinIdx(pinIdx), .holdCycles(holdCycles), .logicIn(logicIn));

   sim_sample_source DUT (.clk(clk), .resetn(resetn), .clkEn(clkEn),
      .simSelect(simSelect), .outputBlockMask(outputBlockMask),
      .faultStartSel(faultStartSel), .playbackStartSel(playbackStartSel),
      .logicIn(logicIn), .relayCmd(relayCmd), .realValid(realValid),
      .realChan(realChan), .realData(realData), .synthData(synthData),
      .pfCurMag(pfCurMag), .pfVoltMag(pfVoltMag), .nominalFreq(nominalFreq),
      .windingShift(windingShift), .faultCurMag(faultCurMag),
      .faultCurAng(faultCurAng), .faultGndMag(faultGndMag),
      .faultGndAng(faultGndAng), .faultVoltMag(faultVoltMag),
      .faultVoltAng(faultVoltAng), .faultFreq(faultFreq),
      .playWrEn(playWrEn), .playWrAddr(playWrAddr), .playWrData(playWrData),
      .simMode(simMode), .sampleValid(sampleValid), .sampleChan(sampleChan),
      .sampleData(sampleData), .genCurMag(genCurMag), .genCurAng(genCurAng),
      .genGndMag(genGndMag), .genGndAng(genGndAng), .genVoltMag(genVoltMag),
      .genVoltAng(genVoltAng), .genFreq(genFreq),
      .inServiceLed(inServiceLed), .testModeLed(testModeLed),
      .selfTestRelay(selfTestRelay), .relayOut(relayOut));

   always #4 clk = ~clk;

   function automatic logic [31:0] nextRand();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : nextRand

   task automatic finishTest();
      if (nErrors == 0 && nCompared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finishTest

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      nCompared++;
      if (got !== exp) begin
         nErrors++;
         $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
      end
   endtask : chk

   // Hang guard, well above the roughly 1200 cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         nErrors++;
         $display("BAD %0t timeout", $time);
         finishTest();
      end
   end

   always @(negedge clk) begin
      if (sampleValid === 1'b1) begin
         if (expQ.size() == 0) begin
            chk(32'h1, 32'h0, "stray sample");
         end else begin
            chk({sampleChan, sampleData}, expQ.pop_front(), "sample");
         end
      end
   end

   task automatic randSettings();
      for (int w = 0; w < 3; w++) begin
         pfCurMag[w] = 9'(nextRand() % 402);
         windingShift[w] = 9'(nextRand() % 360);
         faultGndMag[w] = 9'(nextRand() % 401);
         faultGndAng[w] = 9'(nextRand() % 360);
         for (int p = 0; p < 3; p++) begin
            faultCurMag[w][p] = 9'(nextRand() % 401);
            faultCurAng[w][p] = 9'(nextRand() % 360);
         end
      end
      pfCurMag[0] = 9'h191;
      pfVoltMag = 5'(nextRand() % 22);
      faultVoltMag = 5'(nextRand() % 21);
      faultVoltAng = 9'(nextRand() % 360);
      nominalFreq = 13'h1770;
      faultFreq = 13'(32'h1194 + nextRand() % 1501);
   endtask : randSettings

   task automatic chkState(input logic [1:0] m);
      logic on;
      on = (m != 2'h0);
      chk(simMode, m, "mode");
      chk(inServiceLed, !on, "in service");
      chk(testModeLed, on, "test led");
      chk(selfTestRelay, !on, "self test");
      chk(relayOut, on ? relayCmd & ~outputBlockMask : relayCmd, "relays");
   endtask : chkState

   task automatic setMode(input logic [1:0] m);
      logic [31:0] r;
      r = nextRand();
      relayCmd = r[7:0];
      simSelect = m;
      repeat (4) @(negedge clk);
      chkState(m);
   endtask : setMode

   task automatic sendRound(input logic [1:0] mode, input int rounds);
      logic [31:0] r;
      for (int i = 0; i < rounds * 16; i++) begin
         r = nextRand();
         realValid = 1'b1;
         realChan = i[3:0];
         realData = r[15:0];
         synthData = r[31:16];
         case (mode)
            2'h0: expQ.push_back({i[3:0], r[15:0]});
            2'h3: expQ.push_back({i[3:0], playRec[i[4:0]]});
            default: expQ.push_back({i[3:0], r[31:16]});
         endcase
         @(negedge clk);
         realValid = 1'b0;
         @(negedge clk);
      end
   endtask : sendRound

   task automatic chkPhasors(input logic [1:0] m);
      logic [9:0] a;
      logic [8:0] mag;
      for (int w = 0; w < 3; w++) begin
         for (int p = 0; p < 3; p++) begin
            if (m == 2'h1) begin
               a = {1'b0, windingShift[w]};
               a += (p == 1) ? 10'h0F0 : (p == 2) ? 10'h078 : 10'h000;
               a = (a >= 10'h168) ? a - 10'h168 : a;
               mag = (pfCurMag[w] > sim_source_pkg::CUR_MAG_MAX) ?
                  sim_source_pkg::CUR_MAG_MAX : pfCurMag[w];
               chk(genCurMag[w][p], mag, "pf mag");
               chk(genCurAng[w][p], a, "pf angle");
            end else begin
               a = (w == 0 && p == 0) ? 10'h000 : {1'b0, faultCurAng[w][p]};
               chk(genCurMag[w][p], faultCurMag[w][p], "f mag");
               chk(genCurAng[w][p], a, "f angle");
            end
         end
         if (m == 2'h2) begin
            chk(genGndMag[w], faultGndMag[w], "gnd mag");
            chk(genGndAng[w], faultGndAng[w], "gnd angle");
         end
      end
      if (m == 2'h1) begin
         mag = (pfVoltMag > sim_source_pkg::VOLT_MAG_MAX) ?
            9'(sim_source_pkg::VOLT_MAG_MAX) : 9'(pfVoltMag);
         chk(genVoltMag, mag, "pf volt");
         chk(genFreq, nominalFreq, "pf freq");
      end else begin
         chk(genVoltMag, faultVoltMag, "f volt");
         chk(genVoltAng, faultVoltAng, "f volt angle");
         chk(genFreq, faultFreq, "f freq");
      end
   endtask : chkPhasors

   task automatic trig(input logic [1:0] start, input logic [4:0] fSel,
                       input logic [4:0] pSel, input logic [1:0] expM);
      setMode(2'h0);
      setMode(start);
      faultStartSel = fSel;
      playbackStartSel = pSel;
      press = 1'b1;
      @(negedge clk);
      press = 1'b0;
      repeat (8) @(negedge clk);
      chk(simMode, expM, "trigger");
      if (expM == 2'h3) begin
         sendRound(2'h3, 2);
      end
      setMode(2'h0);
      // Contact may still be closed here: prefault must not move again
      setMode(2'h1);
      letGo = 1'b1;
      @(negedge clk);
      letGo = 1'b0;
   endtask : trig

   initial begin
      logic [31:0] r;
      logic [4:0] s;
      randSettings();
      pfVoltMag = 5'h15;
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
      chkState(2'h0);
      for (int i = 0; i < 32; i++) begin
         r = nextRand();
         playRec[i] = r[15:0];
         playWrEn = 1'b1;
         playWrAddr = 14'(i);
         playWrData = r[15:0];
         @(negedge clk);
      end
      playWrEn = 1'b0;
      sendRound(2'h0, 1);
      setMode(2'h1);
      chkPhasors(2'h1);
      sendRound(2'h1, 1);
      setMode(2'h0);
      randSettings();
      r = nextRand();
      outputBlockMask = r[7:0];
      setMode(2'h1);
      chkPhasors(2'h1);
      // Frozen clock enable: a selector change waits until it is raised
      clkEn = 1'b0;
      simSelect = 2'h2;
      repeat (4) @(negedge clk);
      chk(simMode, 2'h1, "frozen mode");
      clkEn = 1'b1;
      setMode(2'h2);
      chkPhasors(2'h2);
      sendRound(2'h2, 1);
      setMode(2'h3);
      sendRound(2'h3, 2);
      for (int k = 0; k < 4; k++) begin
         r = nextRand();
         pinIdx = r[3:0];
         holdCycles = r[4] ? 8'h00 : 8'h03;
         outputBlockMask = r[15:8];
         s = {1'b0, r[3:0]} + 5'h01;
         trig(2'h1, s, 5'h00, 2'h2);
         trig(2'h1, 5'h00, s, 2'h3);
         trig(2'h1, s, s, 2'h2);
         trig(2'h0, s, s, 2'h0);
         trig(2'h2, 5'h00, s, 2'h2);
         trig(2'h1, 5'h11 + {2'h0, r[7:5]}, 5'h00, 2'h1);
         trig(2'h1, 5'h00, 5'h00, 2'h1);
      end
      // Reset in mid-run clears state; the held selector is taken anew
      relayCmd = 8'hA5;
      resetn = 1'b0;
      @(negedge clk);
      chk(simMode, 2'h0, "reset mode");
      chk(relayOut, 8'h00, "reset relays");
      chk({inServiceLed, selfTestRelay}, 2'h3, "reset leds");
      repeat (9) @(negedge clk);
      resetn = 1'b1;
      setMode(2'h1);
      finishTest();
   end
endmodule : sim_sample_source_tb
`default_nettype wire
